// ==== inc/emo_pkg.sv ====
// Constants, register map and CRC helper for the frame options MAC
package emo_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TX_FRAMES = 8'h08;
    localparam logic [7:0] REG_RX_GOOD = 8'h0c;
    localparam logic [7:0] REG_RX_BAD = 8'h10;
    localparam logic [7:0] REG_RX_OCTETS = 8'h14;
    localparam int CTRL_CRC_BIT = 0;
    localparam int CTRL_PASS_BIT = 1;
    localparam int CTRL_ALIGN_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h5;
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hd5;
    localparam logic [2:0] PRE_LAST = 3'h6;
    localparam logic [1:0] FCS_LAST = 2'h3;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 9;

    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} emo_tx_e;

    function automatic logic [31:0] emo_crc_byte(input logic [31:0] c,
                                                 input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : emo_crc_byte
endpackage : emo_pkg

// ==== rtl/emo_mac.sv ====
// Frame options MAC: TX FIFO, preamble/FCS handling, RX alignment, stats
`timescale 1ns/10ps
`default_nettype none

module emo_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;

    assign level = wp - rp;
    assign in_ready = (level != (AW + 1)'(DEPTH));
    assign out_valid = (wp != rp);
    assign out_data = mem[rp[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule : emo_fifo

module emo_mac import emo_pkg::*; #(
    parameter bit FLOW_CTRL = 1'b0,
    parameter bit TX_STATS = 1'b1,
    parameter bit RX_STATS = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [7:0] line_tx_data,
    output logic line_tx_valid,
    output logic line_tx_last,
    input wire logic [7:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic line_rx_last,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_last,
    output logic rx_fcs_error,
    output logic [1:0] tx_stat_inc,
    output logic [1:0] rx_stat_inc,
    output logic rx_good_octet_count_increment
);
    logic [2:0] ctrl;
    logic crc_ins;
    logic ctrl_pass;
    logic ctrl_align;
    logic f_valid;
    logic f_ready;
    logic [8:0] f_data;
    logic f_in_ready;
    logic [4:0] f_level;
    emo_tx_e tx_state;
    logic [2:0] pre_cnt;
    logic [1:0] fcs_cnt;
    logic [31:0] tx_crc;
    logic tx_in_data;
    logic rx_in_data;
    logic s0_valid, s0_last, s0_crc_en, s0_fwd;
    logic [7:0] s0_data;
    logic s1_fwd, s1_last;
    logic [7:0] s1_data;
    logic [31:0] rx_crc;
    logic rx_err;
    logic [15:0] rx_frame_octets;
    logic [31:0] cnt_tx_frames, cnt_rx_good, cnt_rx_bad, cnt_rx_octets;
    logic [31:0] next_rdata;
    logic mapped;

    assign crc_ins = ctrl[CTRL_CRC_BIT] | FLOW_CTRL;
    assign ctrl_pass = ctrl[CTRL_PASS_BIT];
    assign ctrl_align = ctrl[CTRL_ALIGN_BIT];

    // APB slave: no wait states; pready and read data come from flops set in the setup phase
    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h00000000;
        case (paddr)
            REG_CTRL: next_rdata = {29'h0, ctrl};
            REG_STATUS: next_rdata = {25'h0, f_level, rx_in_data,
                                      tx_state != TX_IDLE};
            REG_TX_FRAMES: next_rdata = cnt_tx_frames;
            REG_RX_GOOD: next_rdata = cnt_rx_good;
            REG_RX_BAD: next_rdata = cnt_rx_bad;
            REG_RX_OCTETS: next_rdata = cnt_rx_octets;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h00000000 : next_rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (psel && penable && pready && pwrite
                     && paddr == REG_CTRL) begin
            ctrl <= pwdata[2:0];
        end
    end

    emo_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(tx_valid),
        .in_ready(f_in_ready),
        .in_data({tx_last, tx_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data),
        .level(f_level)
    );

    assign tx_ready = f_in_ready;
    // Drain stalls during preamble and FCS, so the queue really fills
    assign f_ready = (tx_state == TX_DATA);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            pre_cnt <= 3'h0;
            fcs_cnt <= 2'h0;
            tx_crc <= CRC_INIT;
            tx_in_data <= 1'b0;
            line_tx_data <= 8'h00;
            line_tx_valid <= 1'b0;
            line_tx_last <= 1'b0;
        end else begin
            line_tx_valid <= 1'b0;
            line_tx_last <= 1'b0;
            case (tx_state)
                TX_IDLE: begin
                    tx_crc <= CRC_INIT;
                    pre_cnt <= 3'h0;
                    fcs_cnt <= 2'h0;
                    tx_in_data <= !ctrl_pass;
                    if (f_valid) begin
                        tx_state <= ctrl_pass ? TX_DATA : TX_PRE;
                    end
                end
                TX_PRE: begin
                    line_tx_valid <= 1'b1;
                    line_tx_data <= PRE_BYTE;
                    pre_cnt <= pre_cnt + 3'h1;
                    if (pre_cnt == PRE_LAST) begin
                        tx_state <= TX_PRE;
                        pre_cnt <= pre_cnt + 3'h1;
                    end
                    if (pre_cnt == PRE_LAST + 3'h1) begin
                        line_tx_data <= SFD_BYTE;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (f_valid) begin
                        line_tx_valid <= 1'b1;
                        line_tx_data <= f_data[7:0];
                        if (tx_in_data) begin
                            tx_crc <= emo_crc_byte(tx_crc, f_data[7:0]);
                        end else if (f_data[7:0] == SFD_BYTE) begin
                            tx_in_data <= 1'b1;
                        end
                        if (f_data[8]) begin
                            line_tx_last <= !crc_ins;
                            tx_state <= crc_ins ? TX_FCS : TX_IDLE;
                        end
                    end
                end
                TX_FCS: begin
                    line_tx_valid <= 1'b1;
                    line_tx_data <= ~tx_crc[8*fcs_cnt +: 8];
                    fcs_cnt <= fcs_cnt + 2'h1;
                    if (fcs_cnt == FCS_LAST) begin
                        line_tx_last <= 1'b1;
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_stat_inc <= 2'h0;
        end else begin
            tx_stat_inc[0] <= (tx_state == TX_DATA && f_valid && f_data[8]
                               && !crc_ins)
                              || (tx_state == TX_FCS && fcs_cnt == FCS_LAST);
            tx_stat_inc[1] <= tx_state == TX_DATA && f_valid;
        end
    end

    // Receive front end: find the delimiter, then stage for the check
    assign s0_fwd = s0_valid && (ctrl_pass || s0_crc_en);
    assign rx_err = s1_last && (rx_crc != CRC_RESIDUE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_in_data <= 1'b0;
            s0_valid <= 1'b0;
            s0_last <= 1'b0;
            s0_crc_en <= 1'b0;
            s0_data <= 8'h00;
            s1_fwd <= 1'b0;
            s1_last <= 1'b0;
            s1_data <= 8'h00;
        end else begin
            if (line_rx_valid) begin
                if (line_rx_last) begin
                    rx_in_data <= 1'b0;
                end else if (!rx_in_data && line_rx_data == SFD_BYTE) begin
                    rx_in_data <= 1'b1;
                end
            end
            s0_valid <= line_rx_valid;
            s0_data <= line_rx_data;
            s0_last <= line_rx_valid && line_rx_last && rx_in_data;
            s0_crc_en <= line_rx_valid && rx_in_data;
            s1_fwd <= s0_fwd;
            s1_data <= s0_data;
            s1_last <= s0_last;
        end
    end

    // Check settles one cycle after the last byte; preamble gap covers reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_crc <= CRC_INIT;
            rx_frame_octets <= 16'h0000;
        end else if (s1_last) begin
            rx_crc <= CRC_INIT;
            rx_frame_octets <= 16'h0000;
        end else if (s0_crc_en) begin
            rx_crc <= emo_crc_byte(rx_crc, s0_data);
            rx_frame_octets <= rx_frame_octets + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_last <= 1'b0;
            rx_fcs_error <= 1'b0;
            rx_stat_inc <= 2'h0;
            rx_good_octet_count_increment <= 1'b0;
        end else begin
            if (ctrl_align) begin
                rx_valid <= s1_fwd;
                rx_data <= s1_data;
                rx_last <= s1_last;
            end else begin
                rx_valid <= s0_fwd;
                rx_data <= s0_data;
                rx_last <= s0_last;
            end
            rx_fcs_error <= rx_err;
            rx_stat_inc <= {rx_err, s1_last && !rx_err};
            rx_good_octet_count_increment <= s1_last && !rx_err;
        end
    end

    generate
        if (TX_STATS) begin : g_tx_stats
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_tx_frames <= 32'h00000000;
                end else if (tx_stat_inc[0]) begin
                    cnt_tx_frames <= cnt_tx_frames + 32'h00000001;
                end
            end
        end else begin : g_no_tx_stats
            assign cnt_tx_frames = 32'h00000000;
        end
        if (RX_STATS) begin : g_rx_stats
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_rx_good <= 32'h00000000;
                    cnt_rx_bad <= 32'h00000000;
                    cnt_rx_octets <= 32'h00000000;
                end else if (s1_last) begin
                    if (rx_err) begin
                        cnt_rx_bad <= cnt_rx_bad + 32'h00000001;
                    end else begin
                        cnt_rx_good <= cnt_rx_good + 32'h00000001;
                        cnt_rx_octets <= cnt_rx_octets
                                         + {16'h0000, rx_frame_octets};
                    end
                end
            end
        end else begin : g_no_rx_stats
            assign cnt_rx_good = 32'h00000000;
            assign cnt_rx_bad = 32'h00000000;
            assign cnt_rx_octets = 32'h00000000;
        end
    endgenerate

    property p_flow_crc;
        @(posedge pclk) disable iff (!presetn) FLOW_CTRL |-> crc_ins;
    endproperty
    a_flow_crc: assert property (p_flow_crc)
        else $error("flow control without crc insertion");

    property p_tx_pre;
        @(posedge pclk) disable iff (!presetn)
            $rose(line_tx_valid) && $past(tx_state == TX_PRE)
            |-> line_tx_data == PRE_BYTE;
    endproperty
    a_tx_pre: assert property (p_tx_pre)
        else $error("frame does not open with preamble");

    property p_tx_fcs;
        @(posedge pclk) disable iff (!presetn)
            tx_state == TX_DATA && f_valid && f_data[8] && crc_ins
            |=> !line_tx_last ##4 line_tx_last;
    endproperty
    a_tx_fcs: assert property (p_tx_fcs)
        else $error("fcs not four bytes after payload");

    property p_tx_nocrc;
        @(posedge pclk) disable iff (!presetn)
            tx_state == TX_DATA && f_valid && f_data[8] && !crc_ins
            |=> line_tx_last ##1 !line_tx_valid;
    endproperty
    a_tx_nocrc: assert property (p_tx_nocrc)
        else $error("bytes sent after payload without crc");

    property p_tx_stat;
        @(posedge pclk) disable iff (!presetn)
            line_tx_last |-> tx_stat_inc[0];
    endproperty
    a_tx_stat: assert property (p_tx_stat)
        else $error("frame end without tx increment");

    property p_rx_strip;
        @(posedge pclk) disable iff (!presetn)
            line_rx_valid && !rx_in_data && !ctrl_pass |=> !s0_fwd;
    endproperty
    a_rx_strip: assert property (p_rx_strip)
        else $error("preamble byte forwarded");

    property p_rx_align;
        @(posedge pclk) disable iff (!presetn)
            ctrl_align && s0_last ##1 ctrl_align
            |=> rx_last && rx_fcs_error == $past(rx_err);
    endproperty
    a_rx_align: assert property (p_rx_align)
        else $error("fcs error not aligned with eop");

    property p_rx_noalign;
        @(posedge pclk) disable iff (!presetn)
            !ctrl_align && s0_last |=> rx_last && !rx_fcs_error;
    endproperty
    a_rx_noalign: assert property (p_rx_noalign)
        else $error("unaligned eop timing wrong");

    property p_rx_stat;
        @(posedge pclk) disable iff (!presetn)
            rx_fcs_error |-> rx_stat_inc[1] && !rx_good_octet_count_increment;
    endproperty
    a_rx_stat: assert property (p_rx_stat)
        else $error("bad frame increment missing");
endmodule : emo_mac

`default_nettype wire

// ==== verif/emo_client.sv ====
// Client model: drives the TX byte stream and collects the RX stream
`timescale 1ns/10ps
`default_nettype none

module emo_client (
    input wire logic pclk,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last
);
    logic [7:0] rxq[$];
    int stalls = 0;

    initial begin
        tx_data = 8'h00;
        tx_valid = 1'b0;
        tx_last = 1'b0;
    end

    // Called at a rising edge; in pass-through b holds the own preamble
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            tx_valid <= 1'b1;
            tx_data <= b[i];
            tx_last <= (i == b.size() - 1);
            @(posedge pclk);
            while (tx_ready !== 1'b1) begin
                stalls++;
                @(posedge pclk);
            end
        end
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        // Released bus must not keep showing the last byte
        tx_data <= ~tx_data;
        // Idle edge so a following frame never reassigns tx_valid at once
        @(posedge pclk);
    endtask : send

    // Every byte seen with rx_valid high is queued; rx_last is not used
    always @(posedge pclk) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_data);
        end
    end
endmodule : emo_client

`default_nettype wire

// ==== verif/tb_ethernet_mac_frame_options.sv ====
// Testbench for the frame options MAC with a queue-based reference
`timescale 1ns/10ps
`default_nettype none

module tb_ethernet_mac_frame_options import emo_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] tx_data, line_tx_data, line_rx_data, rx_data;
    logic tx_valid, tx_last, tx_ready, line_tx_valid, line_tx_last;
    logic line_rx_valid, line_rx_last, rx_valid, rx_last, rx_fcs_error;
    logic [1:0] tx_stat_inc, rx_stat_inc;
    logic rx_good_octet_count_increment, e;
    logic [15:0] lfsr = 16'haec6;
    logic [2:0] tx_modes [4] = '{3'h5, 3'h4, 3'h7, 3'h6};
    logic [2:0] rx_modes [3] = '{3'h5, 3'h1, 3'h7};
    int lastq[$];
    int endq[$];
    logic [7:0] ltq[$];
    logic [7:0] expq[$];
    int num_errors = 0, total_checks = 0, cyc = 0;
    int lrx, rl, ec, ng, nb, no, ne, lat_al, lat_un, oct, s0, nt, nsent;

    emo_mac DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .line_tx_data(line_tx_data),
        .line_tx_valid(line_tx_valid), .line_tx_last(line_tx_last),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
        .line_rx_last(line_rx_last), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last),
        .rx_fcs_error(rx_fcs_error), .tx_stat_inc(tx_stat_inc),
        .rx_stat_inc(rx_stat_inc),
        .rx_good_octet_count_increment(rx_good_octet_count_increment));

    emo_client client (.pclk(pclk), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task give_verdict;
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    // Reference checksum, bit-serial, complemented for the wire
    function automatic logic [31:0] fcs(input logic [7:0] q[$]);
        logic [31:0] c;
        c = 32'hffffffff;
        foreach (q[i]) begin
            c = c ^ {24'h000000, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction : fcs

    always @(posedge pclk) begin
        cyc++;
        if (line_tx_valid === 1'b1) ltq.push_back(line_tx_data);
        if (line_tx_last === 1'b1) begin
            check(tx_stat_inc[0], 1'b1);
            lastq.push_back(ltq.size());
        end
        if (tx_stat_inc[1] === 1'b1) nt++;
        if (line_rx_valid === 1'b1 && line_rx_last === 1'b1) lrx = cyc;
        if (rx_last === 1'b1) rl = cyc;
        if (rx_fcs_error === 1'b1) begin
            ec = cyc;
            ne++;
        end
        if (rx_stat_inc[0] === 1'b1) ng++;
        if (rx_stat_inc[1] === 1'b1) nb++;
        if (rx_good_octet_count_increment === 1'b1) no++;
    end

    // Called at a rising edge; waits for pready under a bound
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int t;
        t = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 50) begin
            t++;
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        if (pready !== 1'b1) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps the next setup from reassigning psel at once
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        check(r, x);
    endtask : rchk

    task automatic cmpq(input logic [7:0] g[$], input logic [7:0] x[$]);
        check(g.size(), x.size());
        foreach (x[i]) if (i < g.size()) check(g[i], x[i]);
    endtask : cmpq

    task automatic tx_case(input logic [2:0] ctl, input int n);
        logic [7:0] b[$];
        logic [7:0] p[$];
        logic [31:0] c;
        b = {};
        p = {};
        repeat (7) b.push_back(ctl[1] ? (rnd() & 8'h7f) : PRE_BYTE);
        b.push_back(SFD_BYTE);
        expq = {expq, b};
        repeat (n) p.push_back(rnd());
        c = fcs(p);
        expq = {expq, p};
        if (ctl[0]) for (int k = 0; k < 4; k++) expq.push_back(c[8*k +: 8]);
        endq.push_back(expq.size());
        if (ctl[1]) p = {b, p};
        nsent += p.size();
        client.send(p);
    endtask : tx_case

    task automatic tx_wait();
        int t;
        t = 0;
        while (ltq.size() < expq.size() && t < 3000) begin
            t++;
            @(posedge pclk);
        end
        if (ltq.size() < expq.size()) num_errors++;
        repeat (6) @(posedge pclk);
    endtask : tx_wait

    task automatic rx_case(input logic [2:0] ctl, input bit bad);
        logic [7:0] f[$];
        logic [7:0] p[$];
        logic [31:0] c;
        int g0, b0, o0, e0;
        f = {};
        p = {};
        apb(REG_CTRL, 1'b1, {29'h0, ctl});
        repeat (7) f.push_back(PRE_BYTE);
        f.push_back(SFD_BYTE);
        repeat (5 + rnd() % 8) p.push_back(rnd());
        c = fcs(p) ^ {31'h0, bad};
        f = {f, p};
        for (int k = 0; k < 4; k++) f.push_back(c[8*k +: 8]);
        client.rxq = {};
        g0 = ng;
        b0 = nb;
        o0 = no;
        e0 = ne;
        foreach (f[i]) begin
            line_rx_valid <= 1'b1;
            line_rx_data <= f[i];
            line_rx_last <= (i == f.size() - 1);
            @(posedge pclk);
        end
        line_rx_valid <= 1'b0;
        line_rx_last <= 1'b0;
        line_rx_data <= ~f[f.size() - 1];
        repeat (12) @(posedge pclk);
        if (!ctl[1]) f = f[8:$];
        cmpq(client.rxq, f);
        check(ng - g0, !bad);
        check(nb - b0, bad);
        check(no - o0, !bad);
        check(ne - e0, bad);
        if (!bad) oct += p.size() + 4;
        if (bad && ctl[2]) begin
            lat_al = rl - lrx;
            check(ec, rl);
        end
        if (bad && !ctl[2]) begin
            lat_un = rl - lrx;
            check(ec, rl + 1);
            check(ec - lrx, lat_al);
        end
    endtask : rx_case

    initial begin
        #400000;
        num_errors++;
        give_verdict;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        line_rx_valid = 1'b0;
        line_rx_last = 1'b0;
        line_rx_data = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(REG_CTRL, {29'h0, CTRL_RESET});
        check(tx_ready, 1'b1);
        apb(8'h40, 1'b1, 32'h1);
        check(e, 1'b1);
        rchk(8'h40, 32'h0);
        check(e, 1'b1);
        apb(REG_TX_FRAMES, 1'b1, 32'h123);
        rchk(REG_TX_FRAMES, 32'h0);
        // Each mode: crc, none, pass+crc, pass only
        foreach (tx_modes[i]) begin
            apb(REG_CTRL, 1'b1, {29'h0, tx_modes[i]});
            tx_case(tx_modes[i], 6 + 2 * i);
            tx_wait();
        end
        apb(REG_CTRL, 1'b1, 32'h5);
        s0 = client.stalls;
        // Two long frames back to back overrun the line drain
        tx_case(3'h5, 24);
        tx_case(3'h5, 24);
        tx_wait();
        check(client.stalls > s0, 1'b1);
        rchk(REG_STATUS, 32'h0);
        cmpq(ltq, expq);
        check(lastq.size(), endq.size());
        foreach (endq[i]) if (i < lastq.size()) check(lastq[i], endq[i]);
        check(nt, nsent);
        rchk(REG_TX_FRAMES, 32'd6);
        foreach (rx_modes[i]) begin
            rx_case(rx_modes[i], 1'b0);
            rx_case(rx_modes[i], 1'b1);
        end
        check(lat_al, lat_un + 1);
        rchk(REG_RX_GOOD, 32'd3);
        rchk(REG_RX_BAD, 32'd3);
        rchk(REG_RX_OCTETS, oct);
        give_verdict;
    end
endmodule : tb_ethernet_mac_frame_options

`default_nettype wire
